// >>> test_uus_upstream_sie.sv
/*
 * self-checking bench of the upstream sie control block.
 * assumes the wishbone slave timing of the block and a 100 mhz clock.
 */
`timescale 1ns/1ps
module test_uus_upstream_sie
   import uus_pkg::*;
;
   localparam int FB = 200;
   localparam logic [9:0] RA = {IDX_ADDR_A, 2'b00};
   localparam logic [9:0] RS = {IDX_STAT_CTL, 2'b00};
   localparam logic [9:0] RB = {IDX_ADDR_B, 2'b00};
   // per code {dp_oe, dp, dm_oe, dm}, floating lines read as zero
   localparam logic [31:0] OVR = 32'h082A_ABEB;
   // {cfg, addr b, endpoint, 2'b0}, base, size
   localparam logic [23:0] EPT [20] = '{
      24'h24_D808, 24'h20_E008, 24'h08_E808, 24'h04_F008, 24'h00_F808,
      24'hA0_A808, 24'hA4_B008, 24'h80_B808, 24'h84_C020, 24'h88_E020,
      24'h50_D808, 24'h4C_E008, 24'h48_E808, 24'h44_F008, 24'h40_F808,
      24'hCC_A808, 24'hD0_B008, 24'hC0_B808, 24'hC4_C020, 24'hC8_E020};
   logic clk, resetn, cyc, stb, we, ack, sof, tx_en, tx_dp, tx_dm;
   logic tok_v, hit_a, hit_b, ep_b, f_v, f_rdy, ram_we, stall, mclr, h_en;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic [23:0] t;
   logic [6:0] tok_a;
   logic [2:0] ep_n;
   logic [4:0] f_ofs;
   logic [7:0] f_dat, ram_a, ram_d;
   uus_ep_t ep_info;
   uus_line_t h_line;
   wire uus_drive_t drv;
   wire uus_line_t line;
   int miscompares, total_checks, n;

   uus_upstream_sie #(.FRAME_BIT_TIMES(FB)) DUT (
      .MCLK_IN(clk), .RESETN_IN(resetn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .DP_IN(line.dp),
      .DM_IN(line.dm), .DP_OUT(drv.dp_o), .DP_OE_OUT(drv.dp_oe),
      .DM_OUT(drv.dm_o), .DM_OE_OUT(drv.dm_oe), .SIE_TX_EN_IN(tx_en),
      .SIE_TX_DP_IN(tx_dp), .SIE_TX_DM_IN(tx_dm), .SOF_IN(sof),
      .TOKEN_VALID_IN(tok_v), .TOKEN_ADDR_IN(tok_a), .HIT_A_OUT(hit_a),
      .HIT_B_OUT(hit_b), .EP_ADDR_B_IN(ep_b), .EP_NUM_IN(ep_n),
      .EP_INFO_OUT(ep_info), .EP_MODE_CLR_OUT(mclr),
      .FIFO_WR_VALID_IN(f_v), .FIFO_WR_OFS_IN(f_ofs),
      .FIFO_WR_DATA_IN(f_dat), .FIFO_WR_READY_OUT(f_rdy),
      .RAM_WE_OUT(ram_we), .RAM_ADDR_OUT(ram_a), .RAM_DATA_OUT(ram_d),
      .CPU_STALL_OUT(stall));

   uus_host_model host (.dut_drive_in(drv), .host_en_in(h_en),
      .host_line_in(h_line), .line_out(line));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic tmo(input string nm);
      $display("FAIL %s expected answer seen timeout", nm);
      miscompares++;
      end_of_test();
   endtask

   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) tmo("bus ack");
   endtask

   task automatic rdc(input string nm, input logic [9:0] a,
      input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, {24'h00_0000, e}, rd);
   endtask

   task automatic tok(input logic [6:0] a, input logic [1:0] e);
      @(posedge clk);
      tok_v <= 1'b1;
      tok_a <= a;
      @(posedge clk);
      tok_v <= 1'b0;
      #1;
      chk("token hit", 32'(e), 32'({hit_a, hit_b}));
   endtask

   // counts edges while the pin drive matches p (eq) or differs (!eq)
   task automatic run(input logic [3:0] p, input logic eq);
      n = 0;
      while (((drv === p) === eq) && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 3000) tmo("pin drive");
   endtask

   task automatic fw(input logic b, input logic [2:0] e, input logic [4:0] o,
      input logic [7:0] d, input logic we_e,
      input logic [7:0] ea);
      int k;
      k = 0;
      while (f_rdy !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      f_v <= 1'b1;
      ep_b <= b;
      ep_n <= e;
      f_ofs <= o;
      f_dat <= d;
      @(posedge clk);
      f_v <= 1'b0;
      #1;
      chk("ram we", 32'(we_e), 32'(ram_we));
      chk("fifo ready", 0, 32'(f_rdy));
      if (we_e) begin
         chk("ram addr", 32'(ea), 32'(ram_a));
         chk("ram data", 32'(d), 32'(ram_d));
      end
      k = 0;
      while (stall === 1'b1 && k < 10) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("stall cycles", 3, k);
      chk("fifo ready", 1, 32'(f_rdy));
   endtask

   initial begin
      {resetn, cyc, stb, we, sof, tx_en, tx_dp, tx_dm, tok_v} = '0;
      {ep_b, f_v, h_en, adr, sel, wdat, tok_a, ep_n, f_ofs, f_dat} = '0;
      h_line = '0;
      repeat (4) @(posedge clk);
      #1 chk("mode clear", 1, 32'(mclr));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("mode clear", 0, 32'(mclr));
      rdc("addr a", RA, 8'h00);
      rdc("addr b", RB, 8'h00);
      rdc("status", RS, 8'h20);
      wb(1'b1, 10'h3FC, 8'hFF);
      rdc("unmapped", 10'h3FC, 8'h00);
      $display("test reset finished");
      @(posedge clk);
      sof <= 1'b1;
      wb(1'b1, RS, 8'h00);
      sof <= 1'b0;
      rdc("activity", RS, 8'h20);
      h_en <= 1'b1;
      h_line <= 2'h1;
      repeat (3) @(posedge clk);
      h_en <= 1'b0;
      repeat (4) @(posedge clk);
      rdc("activity", RS, 8'h28);
      wb(1'b1, RS, 8'h08);
      rdc("activity", RS, 8'h28);
      wb(1'b1, RS, 8'h00);
      rdc("activity", RS, 8'h20);
      $display("test activity finished");
      @(posedge clk);
      sof <= 1'b1;
      @(posedge clk);
      sof <= 1'b0;
      #1 run(4'h5, 1'b0);
      // 168 bit times of 100/12 cycles, bit phase free, one output stage
      chk("eop start", 1, 32'(n >= 1393 && n <= 1401));
      run(4'h5, 1'b1);
      chk("eop se0", 1, 32'(n >= 15 && n <= 18));
      run(4'hD, 1'b1);
      chk("eop j", 1, 32'(n >= 7 && n <= 10));
      $display("test eop finished");
      // engine sends k so that suppression shows against the forced codes
      tx_en <= 1'b1;
      tx_dm <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, RS, 8'(c));
         repeat (2) @(posedge clk);
         #1 chk("pins", 32'(OVR[4*c +: 4]), 32'({drv.dp_oe,
            drv.dp_oe & drv.dp_o, drv.dm_oe, drv.dm_oe & drv.dm_o}));
      end
      wb(1'b1, RS, 8'h02);
      repeat (4) @(posedge clk);
      rdc("line state", RS, 8'h1A);
      wb(1'b1, RS, 8'h00);
      tx_en <= 1'b0;
      $display("test override finished");
      wb(1'b1, RA, 8'h05);
      tok(7'h05, 2'h0);
      wb(1'b1, RA, 8'h85);
      rdc("addr a", RA, 8'h85);
      wb(1'b1, RB, 8'h09);
      tok(7'h09, 2'h0);
      wb(1'b1, RB, 8'h89);
      rdc("addr b", RB, 8'h89);
      tok(7'h09, 2'h1);
      tok(7'h05, 2'h2);
      wb(1'b1, RS, 8'h40);
      tok(7'h09, 2'h0);
      $display("test address finished");
      for (int i = 0; i < 20; i++) begin
         t = EPT[i];
         wb(1'b1, RS, {t[23:22], 6'h00});
         ep_b <= t[21];
         ep_n <= t[20:18];
         repeat (2) @(posedge clk);
         #1 chk("endpoint", {13'h0000, t[15:0], 1'b1,
            {2{t[20:18] == 3'h0}}}, 32'(ep_info));
      end
      ep_b <= 1'b1;
      ep_n <= 3'h0;
      repeat (2) @(posedge clk);
      #1 chk("endpoint valid", 0, 32'(ep_info.valid));
      $display("test endpoints finished");
      wb(1'b1, RS, 8'h00);
      fw(1'b0, 3'h1, 5'h03, 8'h5A, 1'b1, 8'hF3);
      fw(1'b0, 3'h1, 5'h07, 8'hA5, 1'b1, 8'hF7);
      fw(1'b0, 3'h1, 5'h08, 8'h3C, 1'b0, 8'h00);
      wb(1'b1, RS, 8'h80);
      fw(1'b0, 3'h2, 5'h1F, 8'hC3, 1'b1, 8'hFF);
      fw(1'b1, 3'h0, 5'h00, 8'h11, 1'b1, 8'hA8);
      $display("test fifo finished");
      end_of_test();
   end
endmodule // test_uus_upstream_sie

// >>> uus_host_model.sv
/*
 * host side of the upstream port: resolves the d+ and d- wires.
 * assumes the block's pin drivers and a bench-driven host transmitter.
 */
`timescale 1ns/1ps
module uus_host_model
   import uus_pkg::*;
(
   // block side drive
   input wire uus_drive_t dut_drive_in,
   // host transmitter
   input wire logic host_en_in,
   input wire uus_line_t host_line_in,
   // resolved wires
   output uus_line_t line_out
);
   // undriven: d+ pull-up gives idle j, d- pull-down
   always_comb begin
      line_out.dp = 1'b1;
      line_out.dm = 1'b0;
      if (host_en_in) begin
         line_out = host_line_in;
      end
      // the block wins so its forced states are seen on readback
      if (dut_drive_in.dp_oe) begin
         line_out.dp = dut_drive_in.dp_o;
      end
      if (dut_drive_in.dm_oe) begin
         line_out.dm = dut_drive_in.dm_o;
      end
   end
endmodule // uus_host_model

// >>> uus_pkg.sv
/*
 * constants, codes and carrier types of the upstream sie control block.
 * assumes a 100 mhz core clock and 32-bit classic wishbone register access.
 */
// Overview of operation
// - Code 000 leaves drivers to the engine
// - Codes 001, 010, 011 force J, K, SE0
// - Codes 100 to 111 force low or float
// - Non-idle upstream event sets sticky activity bit
// - Writing zero clears activity, one keeps it
// - Bits 4 and 5 show live D-, D+
// - Emit end-of-packet at each frame's EOF1; skipped if the engine is transmitting then
// - Two address registers, reset to zero, disabled
// - Respond to an address only when enabled
// - Default: address A three, B two endpoints
// - Bit 7 selects sizes, bit 6 address count
// - Config 00: five 8-byte FIFOs from 0xD8
// - Config 10: three 8-byte, two 32-byte FIFOs
// - Endpoint FIFOs live in shared user RAM
// - Each engine FIFO byte stalls CPU three cycles
// - Endpoint 0 bidirectional, others one direction
// - Reset clears all endpoint mode registers
// - Two-address configs give endpoint 0 control layout
// - Status and control register resets to zero
package uus_pkg;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_ADDR_A = 8'h10;
   localparam logic [7:0] IDX_STAT_CTL = 8'h1f;
   localparam logic [7:0] IDX_ADDR_B = 8'h40;
   localparam int WB_AW = 10;

   // status and control fields
   localparam int SC_OVR_LSB = 0;
   localparam int SC_BUSACT = 3;
   localparam int SC_DM = 4;
   localparam int SC_DP = 5;
   localparam int SC_EPMODE = 6;
   localparam int SC_EPSIZE = 7;
   localparam logic [7:0] STAT_CTL_RST = 8'h00;

   // device address fields
   localparam int AD_EN = 7;
   localparam int AD_W = 7;
   localparam logic [7:0] ADDR_RST = 8'h00;

   typedef enum logic [2:0] {
      OVR_NONE = 3'b000,
      OVR_DP_HI = 3'b001,
      OVR_DM_HI = 3'b010,
      OVR_SE0 = 3'b011,
      OVR_BOTH_LO = 3'b100,
      OVR_DM_LO = 3'b101,
      OVR_DP_LO = 3'b110,
      OVR_FLOAT = 3'b111
   } uus_ovr_t;

   // fifo placement in user ram, small and large sizes
   localparam logic [7:0] FIFO_SMALL = 8'h08;
   localparam logic [7:0] FIFO_LARGE = 8'h20;
   localparam logic [7:0] BS_A0 = 8'hF8;
   localparam logic [7:0] BS_A1 = 8'hF0;
   localparam logic [7:0] BS_A2 = 8'hE8;
   localparam logic [7:0] BS_X3 = 8'hE0;
   localparam logic [7:0] BS_X4 = 8'hD8;
   localparam logic [7:0] BL_X0 = 8'hA8;
   localparam logic [7:0] BL_X1 = 8'hB0;
   localparam logic [7:0] BL_A0 = 8'hB8;
   localparam logic [7:0] BL_A1 = 8'hC0;
   localparam logic [7:0] BL_A2 = 8'hE0;

   // timing
   localparam int CLK_MHZ = 100;
   localparam int BIT_MHZ = 12;
   localparam int FRAME_BITS = 12000;
   localparam int EOF1_BITS = 32;
   localparam int EOP_SE0_BITS = 2;
   localparam int EOP_J_BITS = 1;
   localparam int STALL_CYCLES = 3;

   typedef struct packed {
      logic dp;
      logic dm;
   } uus_line_t;

   typedef struct packed {
      logic dp_o;
      logic dp_oe;
      logic dm_o;
      logic dm_oe;
   } uus_drive_t;

   typedef struct packed {
      logic [7:0] base;
      logic [7:0] size;
      logic valid;
      logic ctrl;
      logic bidir;
   } uus_ep_t;

endpackage

// >>> uus_sync.sv
/*
 * two-flop synchroniser for asynchronous level inputs.
 * assumes inputs are levels held far longer than one clock.
 */
`timescale 1ns/1ps
module uus_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read by the second stage only
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // uus_sync

// >>> uus_upstream_sie.sv
/*
 * upstream sie control: wishbone register slave, line override, activity
 * flag, pin readback, eof1 end-of-packet, address gating, fifo placement
 * and engine fifo byte writes into shared user ram.
 * assumes the engine logic runs on MCLK_IN; the pins are asynchronous.
 */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module uus_upstream_sie
   import uus_pkg::*;
#(
   parameter int FRAME_BIT_TIMES = FRAME_BITS
) (
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   // wishbone slave
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [WB_AW-1:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   // upstream pins
   input wire logic DP_IN,
   input wire logic DM_IN,
   output logic DP_OUT,
   output logic DP_OE_OUT,
   output logic DM_OUT,
   output logic DM_OE_OUT,
   // engine transmit and frame
   input wire logic SIE_TX_EN_IN,
   input wire logic SIE_TX_DP_IN,
   input wire logic SIE_TX_DM_IN,
   input wire logic SOF_IN,
   // token address match
   input wire logic TOKEN_VALID_IN,
   input wire logic [6:0] TOKEN_ADDR_IN,
   output logic HIT_A_OUT,
   output logic HIT_B_OUT,
   // endpoint lookup
   input wire logic EP_ADDR_B_IN,
   input wire logic [2:0] EP_NUM_IN,
   output uus_ep_t EP_INFO_OUT,
   output logic EP_MODE_CLR_OUT,
   // engine fifo byte write into user ram
   input wire logic FIFO_WR_VALID_IN,
   input wire logic [4:0] FIFO_WR_OFS_IN,
   input wire logic [7:0] FIFO_WR_DATA_IN,
   output logic FIFO_WR_READY_OUT,
   output logic RAM_WE_OUT,
   output logic [7:0] RAM_ADDR_OUT,
   output logic [7:0] RAM_DATA_OUT,
   output logic CPU_STALL_OUT
);
   localparam int BIT_INC = BIT_MHZ;
   localparam int BIT_WRAP = CLK_MHZ;
   localparam int EOF1_AT = FRAME_BIT_TIMES - EOF1_BITS;

   logic [7:0] addr_a_q;
   logic [7:0] addr_b_q;
   logic [2:0] ovr_q;
   logic busact_q;
   logic [1:0] epcfg_q;
   logic ack_q;
   logic [31:0] dat_q;
   uus_line_t line_s;
   uus_drive_t drv_q;
   uus_drive_t drv_d;

   // pins pass two flops before anything reads them
   uus_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_in(MCLK_IN),
      .resetn_in(RESETN_IN),
      .async_in({DP_IN, DM_IN}),
      .sync_out(line_s)
   );

   // bus decode
   logic req;
   logic wr;
   logic [7:0] idx;
   logic lane0;
   assign req = WB_CYC_IN & WB_STB_IN & ~ack_q;
   assign wr = req & WB_WE_IN;
   assign idx = WB_ADR_IN[WB_AW-1:2];
   assign lane0 = WB_SEL_IN[0];

   // one answer per request after one wait cycle, dropped the cycle after
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // read data, unmapped and reserved read zero
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         dat_q <= 32'h0000_0000;
      end else if (req && !WB_WE_IN) begin
         case (idx)
            IDX_ADDR_A: dat_q <= {24'h00_0000, addr_a_q};
            IDX_ADDR_B: dat_q <= {24'h00_0000, addr_b_q};
            IDX_STAT_CTL: dat_q <= {24'h00_0000, epcfg_q, line_s.dp,
               line_s.dm, busact_q, ovr_q};
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end
   assign WB_DAT_OUT = dat_q;
   assign WB_ACK_OUT = ack_q;

   // address registers, cleared by reset
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         addr_a_q <= ADDR_RST;
         addr_b_q <= ADDR_RST;
      end else if (wr && lane0) begin
         if (idx == IDX_ADDR_A) begin
            addr_a_q <= WB_DAT_IN[7:0];
         end
         if (idx == IDX_ADDR_B) begin
            addr_b_q <= WB_DAT_IN[7:0];
         end
      end
   end

   // status and control writable fields
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ovr_q <= STAT_CTL_RST[SC_OVR_LSB +: 3];
         epcfg_q <= STAT_CTL_RST[SC_EPMODE +: 2];
      end else if (wr && lane0 && idx == IDX_STAT_CTL) begin
         ovr_q <= WB_DAT_IN[SC_OVR_LSB +: 3];
         epcfg_q <= {WB_DAT_IN[SC_EPSIZE], WB_DAT_IN[SC_EPMODE]};
      end
   end

   // anything but idle J counts as activity; the synchroniser leaves
   // reset at se0, so ignore it until it has refilled from the pins
   logic act_evt;
   logic act_clr;
   logic [1:0] sync_fill_q;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sync_fill_q <= 2'b00;
      end else begin
         sync_fill_q <= {sync_fill_q[0], 1'b1};
      end
   end
   assign act_evt = sync_fill_q[1] & ~(line_s.dp & ~line_s.dm);
   assign act_clr = wr && lane0 && idx == IDX_STAT_CTL &&
      !WB_DAT_IN[SC_BUSACT];

   // set beats clear so a late event is never lost
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         busact_q <= STAT_CTL_RST[SC_BUSACT];
      end else if (act_evt) begin
         busact_q <= 1'b1;
      end else if (act_clr) begin
         busact_q <= 1'b0;
      end
   end

   // bit-rate enable: fractional divider, 12 of every 100 cycles
   logic [6:0] acc_q;
   logic bit_en;
   logic [7:0] acc_sum;
   assign acc_sum = {1'b0, acc_q} + 8'(BIT_INC);
   assign bit_en = acc_sum >= 8'(BIT_WRAP);
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         acc_q <= 7'h00;
      end else if (bit_en) begin
         acc_q <= 7'(acc_sum - 8'(BIT_WRAP));
      end else begin
         acc_q <= acc_sum[6:0];
      end
   end

   // frame position in bit times, realigned on each sof
   logic [13:0] fbit_q;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         fbit_q <= 14'h0000;
      end else if (SOF_IN) begin
         fbit_q <= 14'h0000;
      end else if (bit_en && fbit_q != 14'(FRAME_BIT_TIMES - 1)) begin
         fbit_q <= fbit_q + 14'h0001;
      end
   end

   typedef enum logic [1:0] {
      EOP_IDLE = 2'b00,
      EOP_SE0 = 2'b01,
      EOP_J = 2'b10
   } uus_eop_t;
   uus_eop_t eop_q;
   logic [1:0] eop_cnt_q;

   // se0 for two bit times then j for one, at eof1
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         eop_q <= EOP_IDLE;
         eop_cnt_q <= 2'b00;
      end else if (bit_en) begin
         case (eop_q)
            EOP_IDLE: begin
               // start as the count steps onto eof1, not one bit later
               if (fbit_q == 14'(EOF1_AT - 1) && !SIE_TX_EN_IN) begin
                  eop_q <= EOP_SE0;
                  eop_cnt_q <= 2'(EOP_SE0_BITS - 1);
               end
            end
            EOP_SE0: begin
               if (eop_cnt_q == 2'b00) begin
                  eop_q <= EOP_J;
                  eop_cnt_q <= 2'(EOP_J_BITS - 1);
               end else begin
                  eop_cnt_q <= eop_cnt_q - 2'b01;
               end
            end
            EOP_J: begin
               if (eop_cnt_q == 2'b00) begin
                  eop_q <= EOP_IDLE;
               end else begin
                  eop_cnt_q <= eop_cnt_q - 2'b01;
               end
            end
            default: eop_q <= EOP_IDLE;
         endcase
      end
   end

   // driver select: override, then hub eop, then the engine
   always_comb begin
      drv_d = '{dp_o: SIE_TX_DP_IN, dp_oe: SIE_TX_EN_IN,
         dm_o: SIE_TX_DM_IN, dm_oe: SIE_TX_EN_IN};
      if (eop_q == EOP_SE0) begin
         drv_d = '{dp_o: 1'b0, dp_oe: 1'b1, dm_o: 1'b0, dm_oe: 1'b1};
      end else if (eop_q == EOP_J) begin
         drv_d = '{dp_o: 1'b1, dp_oe: 1'b1, dm_o: 1'b0, dm_oe: 1'b1};
      end
      // engine drive is dropped whenever a code is held
      case (uus_ovr_t'(ovr_q))
         OVR_NONE: ;
         OVR_DP_HI: drv_d = '{dp_o: 1'b1, dp_oe: 1'b1,
            dm_o: 1'b0, dm_oe: 1'b1};
         OVR_DM_HI: drv_d = '{dp_o: 1'b0, dp_oe: 1'b1,
            dm_o: 1'b1, dm_oe: 1'b1};
         OVR_SE0: drv_d = '{dp_o: 1'b0, dp_oe: 1'b1,
            dm_o: 1'b0, dm_oe: 1'b1};
         OVR_BOTH_LO: drv_d = '{dp_o: 1'b0, dp_oe: 1'b1,
            dm_o: 1'b0, dm_oe: 1'b1};
         OVR_DM_LO: drv_d = '{dp_o: 1'b0, dp_oe: 1'b0,
            dm_o: 1'b0, dm_oe: 1'b1};
         OVR_DP_LO: drv_d = '{dp_o: 1'b0, dp_oe: 1'b1,
            dm_o: 1'b0, dm_oe: 1'b0};
         OVR_FLOAT: drv_d = '{dp_o: 1'b0, dp_oe: 1'b0,
            dm_o: 1'b0, dm_oe: 1'b0};
         default: ;
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end
   assign DP_OUT = drv_q.dp_o;
   assign DP_OE_OUT = drv_q.dp_oe;
   assign DM_OUT = drv_q.dm_o;
   assign DM_OE_OUT = drv_q.dm_oe;

   // address b exists only in two-address configurations
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         HIT_A_OUT <= 1'b0;
         HIT_B_OUT <= 1'b0;
      end else begin
         HIT_A_OUT <= TOKEN_VALID_IN && addr_a_q[AD_EN] &&
            TOKEN_ADDR_IN == addr_a_q[AD_W-1:0];
         HIT_B_OUT <= TOKEN_VALID_IN && addr_b_q[AD_EN] && !epcfg_q[0] &&
            TOKEN_ADDR_IN == addr_b_q[AD_W-1:0];
      end
   end

   // fifo placement for each configuration
   function automatic uus_ep_t ep_lookup(input logic [1:0] cfg,
      input logic sel_b, input logic [2:0] ep);
      uus_ep_t r;
      r = '{base: 8'h00, size: FIFO_SMALL, valid: 1'b1,
         ctrl: 1'b0, bidir: 1'b0};
      case ({cfg, sel_b, ep})
         {2'b00, 1'b0, 3'd0}, {2'b01, 1'b0, 3'd0}: r.base = BS_A0;
         {2'b00, 1'b0, 3'd1}, {2'b01, 1'b0, 3'd1}: r.base = BS_A1;
         {2'b00, 1'b0, 3'd2}, {2'b01, 1'b0, 3'd2}: r.base = BS_A2;
         {2'b00, 1'b1, 3'd0}, {2'b01, 1'b0, 3'd3}: r.base = BS_X3;
         {2'b00, 1'b1, 3'd1}, {2'b01, 1'b0, 3'd4}: r.base = BS_X4;
         {2'b10, 1'b1, 3'd0}, {2'b11, 1'b0, 3'd3}: r.base = BL_X0;
         {2'b10, 1'b1, 3'd1}, {2'b11, 1'b0, 3'd4}: r.base = BL_X1;
         {2'b10, 1'b0, 3'd0}, {2'b11, 1'b0, 3'd0}: r.base = BL_A0;
         {2'b10, 1'b0, 3'd1}, {2'b11, 1'b0, 3'd1}: begin
            r.base = BL_A1;
            r.size = FIFO_LARGE;
         end
         {2'b10, 1'b0, 3'd2}, {2'b11, 1'b0, 3'd2}: begin
            r.base = BL_A2;
            r.size = FIFO_LARGE;
         end
         default: begin
            r.size = 8'h00;
            r.valid = 1'b0;
         end
      endcase
      // endpoint 0 of each address is the control endpoint
      r.ctrl = r.valid && ep == 3'd0;
      r.bidir = r.valid && ep == 3'd0;
      return r;
   endfunction

   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         EP_INFO_OUT <= '0;
      end else begin
         EP_INFO_OUT <= ep_lookup(epcfg_q, EP_ADDR_B_IN, EP_NUM_IN);
      end
   end

   // clear for the mode registers held beside this block, high through reset until the first clock after release
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         EP_MODE_CLR_OUT <= 1'b1;
      end else begin
         EP_MODE_CLR_OUT <= 1'b0;
      end
   end

   // engine byte writes own the ram bus; cpu waits meanwhile
   logic [1:0] stall_q;
   logic fifo_take;
   uus_ep_t wr_ep;
   assign wr_ep = ep_lookup(epcfg_q, EP_ADDR_B_IN, EP_NUM_IN);
   assign FIFO_WR_READY_OUT = stall_q == 2'b00;
   assign fifo_take = FIFO_WR_VALID_IN && FIFO_WR_READY_OUT;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         stall_q <= 2'b00;
      end else if (fifo_take) begin
         stall_q <= 2'(STALL_CYCLES);
      end else if (stall_q != 2'b00) begin
         stall_q <= stall_q - 2'b01;
      end
   end
   assign CPU_STALL_OUT = stall_q != 2'b00;

   // out-of-range offsets still occupy the bus but do not write
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         RAM_WE_OUT <= 1'b0;
         RAM_ADDR_OUT <= 8'h00;
         RAM_DATA_OUT <= 8'h00;
      end else begin
         RAM_WE_OUT <= fifo_take && wr_ep.valid &&
            {3'b000, FIFO_WR_OFS_IN} < wr_ep.size;
         if (fifo_take) begin
            RAM_ADDR_OUT <= wr_ep.base + {3'b000, FIFO_WR_OFS_IN};
            RAM_DATA_OUT <= FIFO_WR_DATA_IN;
         end
      end
   end

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   a_no_force_pass: assert property (
      ovr_q == 3'b000 && eop_q == EOP_IDLE && $stable(ovr_q) |=>
      DP_OE_OUT == $past(SIE_TX_EN_IN) && DP_OUT == $past(SIE_TX_DP_IN))
      else $error("engine drive not passed through");
   a_force_diff: assert property (
      ovr_q == 3'b010 |=> !DP_OUT && DP_OE_OUT && DM_OUT && DM_OE_OUT)
      else $error("code 010 not forcing K");
   a_force_float: assert property (
      ovr_q == 3'b101 |=> !DP_OE_OUT && DM_OE_OUT && !DM_OUT)
      else $error("code 101 drive wrong");
   a_override_wins: assert property (
      ovr_q == 3'b111 && SIE_TX_EN_IN |=> !DP_OE_OUT && !DM_OE_OUT)
      else $error("engine drove through override");
   a_activity_set: assert property (
      act_evt |=> busact_q)
      else $error("activity event lost");
   a_activity_keep: assert property (
      busact_q && !act_clr |=> busact_q)
      else $error("activity flag dropped without clear");
   a_pin_readback: assert property (
      ack_q && !WB_WE_IN && idx == IDX_STAT_CTL |->
      WB_DAT_OUT[5:4] == $past({line_s.dp, line_s.dm}))
      else $error("pin readback mismatch");
   a_addr_gate: assert property (
      HIT_A_OUT |-> $past(addr_a_q[AD_EN]))
      else $error("hit on disabled address");
   a_stall_len: assert property (
      fifo_take |=> CPU_STALL_OUT [*3] ##1 FIFO_WR_READY_OUT)
      else $error("cpu stall not three cycles");
   a_eop_se0: assert property (
      $rose(eop_q == EOP_SE0) |=> !DP_OUT && !DM_OUT && DP_OE_OUT ||
      ovr_q != 3'b000)
      else $error("eop not driving se0");
endmodule // uus_upstream_sie
